// *** sbt_pkg.sv ***
// Constants and types for the SRAM boundary scan test port
// Function
// - Bypass 111 puts one-bit bypass in path
// - Sample/preload 100 captures pins at Capture-DR
// - Non-pin scan cells capture fixed default
// - All-zero code executes external test
// - External test never gates functional inputs
// - External test drives scan cells at Update-IR fall
// - External test captures pins, outputs follow cells
// - Identification 001 loads ROM, shifts it out
// - Identification active at reset and Test-Logic-Reset
// - Float-and-sample 010 floats outputs, scans ring
// - Reserved codes 011, 110 act as bypass
// - Codes are binary, MSB leftmost
// - Three-bit instructions take effect at Update-IR
// - Capture-IR loads 01 into low bits
// - Five TMS-high edges reach Test-Logic-Reset
// - 32-bit identification shifts LSB first
package sbt_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 8;
  localparam int PIN_W = 6;
  localparam int OUT_W = 4;
  localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  // Identification value is arbitrary
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0a5f;
  // Place holder cells sit above the pin cells and load this value at Capture-DR
  localparam logic [BSR_W-PIN_W-1:0] BSR_FILL = 2'h3;
  localparam logic [1:0] DEF_EDGE_NONE = 2'h0;
  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR,
    TS_UP_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UP_IR
  } sbt_state_e;
endpackage : sbt_pkg

// *** sbt_sync.sv ***
// Two-flop synchroniser with edge detection on the second stage
`timescale 1ns/10ps
module sbt_sync (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout,
  output logic rise,
  output logic fall
);
  logic meta;
  logic prev;
  logic next_meta;
  logic next_dout;
  logic next_prev;
  always_comb begin
    next_meta = din;
    next_dout = meta;
    next_prev = dout;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta <= 1'b1;
      dout <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
      prev <= next_prev;
    end
  end
  assign rise = dout & ~prev;
  assign fall = ~dout & prev;
endmodule : sbt_sync

// *** sbt_fsm.sv ***
// Test access port state machine, advanced on test clock rising edges
`timescale 1ns/10ps
module sbt_fsm (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic step,
  input wire logic tms,
  output sbt_pkg::sbt_state_e state
);
  sbt_pkg::sbt_state_e next_state;
  always_comb begin
    next_state = state;
    if (step) begin
      case (state)
        sbt_pkg::TS_RESET: next_state = tms ? sbt_pkg::TS_RESET : sbt_pkg::TS_IDLE;
        sbt_pkg::TS_IDLE: next_state = tms ? sbt_pkg::TS_SEL_DR : sbt_pkg::TS_IDLE;
        sbt_pkg::TS_SEL_DR: next_state = tms ? sbt_pkg::TS_SEL_IR : sbt_pkg::TS_CAP_DR;
        sbt_pkg::TS_CAP_DR: next_state = tms ? sbt_pkg::TS_EX1_DR : sbt_pkg::TS_SH_DR;
        sbt_pkg::TS_SH_DR: next_state = tms ? sbt_pkg::TS_EX1_DR : sbt_pkg::TS_SH_DR;
        sbt_pkg::TS_EX1_DR: next_state = tms ? sbt_pkg::TS_UP_DR : sbt_pkg::TS_PA_DR;
        sbt_pkg::TS_PA_DR: next_state = tms ? sbt_pkg::TS_EX2_DR : sbt_pkg::TS_PA_DR;
        sbt_pkg::TS_EX2_DR: next_state = tms ? sbt_pkg::TS_UP_DR : sbt_pkg::TS_SH_DR;
        sbt_pkg::TS_UP_DR: next_state = tms ? sbt_pkg::TS_SEL_DR : sbt_pkg::TS_IDLE;
        // High edge here enters reset; from any state this is at most the fifth
        sbt_pkg::TS_SEL_IR: next_state = tms ? sbt_pkg::TS_RESET : sbt_pkg::TS_CAP_IR;
        sbt_pkg::TS_CAP_IR: next_state = tms ? sbt_pkg::TS_EX1_IR : sbt_pkg::TS_SH_IR;
        sbt_pkg::TS_SH_IR: next_state = tms ? sbt_pkg::TS_EX1_IR : sbt_pkg::TS_SH_IR;
        sbt_pkg::TS_EX1_IR: next_state = tms ? sbt_pkg::TS_UP_IR : sbt_pkg::TS_PA_IR;
        sbt_pkg::TS_PA_IR: next_state = tms ? sbt_pkg::TS_EX2_IR : sbt_pkg::TS_PA_IR;
        sbt_pkg::TS_EX2_IR: next_state = tms ? sbt_pkg::TS_UP_IR : sbt_pkg::TS_SH_IR;
        sbt_pkg::TS_UP_IR: next_state = tms ? sbt_pkg::TS_SEL_DR : sbt_pkg::TS_IDLE;
        default: next_state = sbt_pkg::TS_RESET;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= sbt_pkg::TS_RESET;
    end else begin
      state <= next_state;
    end
  end
endmodule : sbt_fsm

// *** sbt_tap.sv ***
// Boundary scan test port top: instruction decode and data register selection
`timescale 1ns/10ps
module sbt_tap (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [sbt_pkg::PIN_W-1:0] pin_in,
  output logic tdo,
  output logic tdo_oe,
  output logic [sbt_pkg::OUT_W-1:0] scan_out,
  output logic scan_out_sel,
  output logic ram_out_float,
  output logic [sbt_pkg::IR_W-1:0] active_op
);
  logic tck_s;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  logic [sbt_pkg::PIN_W-1:0] pin_s;
  logic [sbt_pkg::PIN_W-1:0] pin_m;
  sbt_pkg::sbt_state_e state;

  sbt_sync u_tck (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(tck),
    .dout(tck_s),
    .rise(tck_rise),
    .fall(tck_fall)
  );
  sbt_sync u_tms (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(tms),
    .dout(tms_s),
    .rise(),
    .fall()
  );
  sbt_sync u_tdi (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(tdi),
    .dout(tdi_s),
    .rise(),
    .fall()
  );
  // Pin levels only matter at capture; the controller holds them steady there
  always_ff @(posedge core_clk) begin
    pin_m <= pin_in;
    pin_s <= pin_m;
  end

  sbt_fsm u_fsm (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .step(tck_rise),
    .tms(tms_s),
    .state(state)
  );

  logic [sbt_pkg::IR_W-1:0] ir_sh;
  logic [sbt_pkg::IR_W-1:0] op;
  logic [sbt_pkg::ID_W-1:0] id_sh;
  logic [sbt_pkg::BSR_W-1:0] bsr;
  logic byp;
  logic up_ir_seen;
  logic [sbt_pkg::IR_W-1:0] next_ir_sh;
  logic [sbt_pkg::IR_W-1:0] next_op;
  logic [sbt_pkg::ID_W-1:0] next_id_sh;
  logic [sbt_pkg::BSR_W-1:0] next_bsr;
  logic next_byp;
  logic next_up_ir_seen;
  logic sel_bsr;
  logic sel_id;

  // Codes compared MSB-first as printed; private 101 and reserved codes fall to bypass
  always_comb begin
    sel_bsr = (op == sbt_pkg::OP_EXTEST) || (op == sbt_pkg::OP_SAMPLE)
      || (op == sbt_pkg::OP_SAMPLE_Z);
    sel_id = (op == sbt_pkg::OP_IDCODE);
  end

  always_comb begin
    next_ir_sh = ir_sh;
    next_op = op;
    next_id_sh = id_sh;
    next_bsr = bsr;
    next_byp = byp;
    next_up_ir_seen = up_ir_seen;
    if (state == sbt_pkg::TS_RESET) begin
      next_op = sbt_pkg::OP_IDCODE;
    end
    if (tck_rise) begin
      case (state)
        sbt_pkg::TS_CAP_IR: begin
          next_ir_sh = {op[sbt_pkg::IR_W-1:2], sbt_pkg::IR_CAPTURE};
        end
        sbt_pkg::TS_SH_IR: begin
          next_ir_sh = {tdi_s, ir_sh[sbt_pkg::IR_W-1:1]};
        end
        sbt_pkg::TS_CAP_DR: begin
          if (sel_id) begin
            next_id_sh = sbt_pkg::ID_VALUE;
          end else if (sel_bsr) begin
            // Pins into low cells, fixed default into the rest
            next_bsr = {sbt_pkg::BSR_FILL, pin_s};
          end else begin
            next_byp = 1'b0;
          end
        end
        sbt_pkg::TS_SH_DR: begin
          if (sel_id) begin
            next_id_sh = {tdi_s, id_sh[sbt_pkg::ID_W-1:1]};
          end else if (sel_bsr) begin
            next_bsr = {tdi_s, bsr[sbt_pkg::BSR_W-1:1]};
          end else begin
            next_byp = tdi_s;
          end
        end
        default: begin
        end
      endcase
    end
    // New instruction acts on the falling edge in Update-IR
    next_up_ir_seen = (state == sbt_pkg::TS_UP_IR);
    if (tck_fall && state == sbt_pkg::TS_UP_IR) begin
      next_op = ir_sh;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ir_sh <= sbt_pkg::OP_IDCODE;
      op <= sbt_pkg::OP_IDCODE;
      id_sh <= sbt_pkg::ID_VALUE;
      bsr <= '0;
      byp <= 1'b0;
      up_ir_seen <= 1'b0;
    end else begin
      ir_sh <= next_ir_sh;
      op <= next_op;
      id_sh <= next_id_sh;
      bsr <= next_bsr;
      byp <= next_byp;
      up_ir_seen <= next_up_ir_seen;
    end
  end

  // Serial output and its enable change on the test clock falling edge
  logic next_tdo;
  logic next_tdo_oe;
  logic [sbt_pkg::OUT_W-1:0] next_scan_out;
  logic next_scan_out_sel;
  logic next_float;
  logic shifting;

  always_comb begin
    shifting = (state == sbt_pkg::TS_SH_DR) || (state == sbt_pkg::TS_SH_IR);
    next_tdo = tdo;
    next_tdo_oe = tdo_oe;
    next_scan_out = scan_out;
    next_scan_out_sel = scan_out_sel;
    next_float = ram_out_float;
    if (tck_fall) begin
      next_tdo_oe = shifting;
      if (state == sbt_pkg::TS_SH_IR) begin
        next_tdo = ir_sh[0];
      end else if (sel_id) begin
        next_tdo = id_sh[0];
      end else if (sel_bsr) begin
        next_tdo = bsr[0];
      end else begin
        next_tdo = byp;
      end
    end
    // Output cells follow the scan register while external test holds
    next_scan_out_sel = (op == sbt_pkg::OP_EXTEST);
    if (op == sbt_pkg::OP_EXTEST) begin
      next_scan_out = bsr[sbt_pkg::OUT_W-1:0];
    end
    next_float = (op == sbt_pkg::OP_SAMPLE_Z);
  end

  // Functional inputs are never gated here: only outputs are steered
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      scan_out <= '0;
      scan_out_sel <= 1'b0;
      ram_out_float <= 1'b0;
      active_op <= sbt_pkg::OP_IDCODE;
    end else begin
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
      scan_out <= next_scan_out;
      scan_out_sel <= next_scan_out_sel;
      ram_out_float <= next_float;
      active_op <= op;
    end
  end

  // Checks
  sequence upd_fall_s;
    tck_fall && state == sbt_pkg::TS_UP_IR;
  endsequence

  property op_update_p;
    @(posedge core_clk) disable iff (!reset_n)
    upd_fall_s |=> (op == $past(ir_sh));
  endproperty
  op_update_a: assert property (op_update_p)
    else $error("instruction not updated at Update-IR");

  op_hold_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(tck_fall && state == sbt_pkg::TS_UP_IR) && state != sbt_pkg::TS_RESET
    |=> $stable(op))
    else $error("instruction changed outside Update-IR");

  reset_id_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    state == sbt_pkg::TS_RESET |=> op == sbt_pkg::OP_IDCODE)
    else $error("identification not active in reset state");

  cap_ir_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    tck_rise && state == sbt_pkg::TS_CAP_IR |=> ir_sh[1:0] == sbt_pkg::IR_CAPTURE)
    else $error("capture-IR pattern wrong");

  cap_id_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    tck_rise && state == sbt_pkg::TS_CAP_DR && sel_id |=> id_sh == sbt_pkg::ID_VALUE)
    else $error("identification not loaded");

  cap_fill_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    tck_rise && state == sbt_pkg::TS_CAP_DR && sel_bsr
    |=> bsr[sbt_pkg::BSR_W-1:sbt_pkg::PIN_W] == sbt_pkg::BSR_FILL)
    else $error("place holder cells not defaulted");

  float_sz_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ram_out_float == $past(op == sbt_pkg::OP_SAMPLE_Z))
    else $error("float output wrong");

  byp_out_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    tck_fall && state == sbt_pkg::TS_SH_DR && !sel_id && !sel_bsr |=> tdo == $past(byp))
    else $error("bypass bit not on serial output");

  extest_drv_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    op == sbt_pkg::OP_EXTEST ##1 op == sbt_pkg::OP_EXTEST
    |-> scan_out == $past(bsr[sbt_pkg::OUT_W-1:0]) && scan_out_sel)
    else $error("scan cells not driven under external test");
endmodule : sbt_tap

// *** sbt_ctl_model.sv ***
// Behavioural board-level scan controller driving the test port pins
`timescale 1ns/10ps
module sbt_ctl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  localparam int HALF_NS = 16;

  // Pull-ups hold all three lines high while no frame runs
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // Lines change only while the clock is low, so each rising edge sees settled values
  task automatic step(input logic m, input logic d);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #(HALF_NS);
    tck = 1'b1;
    #(HALF_NS);
  endtask : step

  task automatic park();
    tms = 1'b1;
    tdi = 1'b1;
  endtask : park

  task automatic go_reset();
    for (int i = 0; i < 5; i++) begin
      step(1'b1, 1'b1);
    end
    step(1'b0, 1'b1);
    park();
  endtask : go_reset

  // Output is read late in the high phase, well after it moved on the falling edge
  task automatic load_ir(input logic [sbt_pkg::IR_W-1:0] code,
                         output logic [sbt_pkg::IR_W-1:0] cap);
    step(1'b1, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < sbt_pkg::IR_W; i++) begin
      step(i == sbt_pkg::IR_W - 1, code[i]);
      cap[i] = tdo;
    end
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    park();
  endtask : load_ir

  task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = tdo;
    end
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    park();
  endtask : scan_dr
endmodule : sbt_ctl_model

// *** tb_top.sv ***
// Self-checking bench for the boundary scan test port
`timescale 1ns/10ps
module tb_top;
  logic core_clk;
  logic reset_n;
  logic [sbt_pkg::PIN_W-1:0] pin_in;
  logic tck, tms, tdi, tdo, tdo_oe, scan_out_sel, ram_out_float;
  logic [sbt_pkg::OUT_W-1:0] scan_out;
  logic [sbt_pkg::IR_W-1:0] active_op;
  logic [sbt_pkg::IR_W-1:0] ir_cap;
  logic [31:0] dr_out;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;

  sbt_tap uut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .pin_in(pin_in),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .scan_out(scan_out),
    .scan_out_sel(scan_out_sel),
    .ram_out_float(ram_out_float),
    .active_op(active_op)
  );

  sbt_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    core_clk = 1'b0;
    forever begin
      #2 core_clk = ~core_clk;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // The whole run needs about 2060 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic set_pins(input logic [sbt_pkg::PIN_W-1:0] v);
    @(posedge core_clk);
    pin_in <= v;
  endtask : set_pins

  task automatic t_idcode();
    check(active_op, sbt_pkg::OP_IDCODE);
    check({tdo_oe, scan_out_sel, ram_out_float}, 3'h0);
    // Controller rests in Test-Logic-Reset after power-up; the IR walk starts from idle
    ctl.step(1'b0, 1'b1);
    ctl.load_ir(sbt_pkg::OP_IDCODE, ir_cap);
    check(ir_cap[1:0], sbt_pkg::IR_CAPTURE);
    ctl.scan_dr(sbt_pkg::ID_W, 32'h0000_0000, dr_out);
    check(dr_out, sbt_pkg::ID_VALUE);
  endtask : t_idcode

  // Bypass captures 0, so the pattern comes back one bit late
  task automatic t_bypass();
    // Reserved codes appear only here, to prove they fall back to bypass
    logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h6, 3'h5};
    for (int i = 0; i < 4; i++) begin
      ctl.load_ir(codes[i], ir_cap);
      check(ir_cap[1:0], sbt_pkg::IR_CAPTURE);
      check(active_op, codes[i]);
      ctl.scan_dr(8, 32'h0000_00b4, dr_out);
      check(dr_out, 32'h0000_0068);
      check({scan_out_sel, ram_out_float}, 2'h0);
    end
  endtask : t_bypass

  task automatic t_sample_extest();
    set_pins(6'h2d);
    ctl.load_ir(sbt_pkg::OP_SAMPLE, ir_cap);
    ctl.scan_dr(sbt_pkg::BSR_W, 32'h0000_00c3, dr_out);
    check(dr_out, {sbt_pkg::BSR_FILL, 6'h2d});
    ctl.load_ir(sbt_pkg::OP_EXTEST, ir_cap);
    check(active_op, sbt_pkg::OP_EXTEST);
    check({scan_out_sel, scan_out}, 5'h13);
    set_pins(6'h16);
    ctl.scan_dr(sbt_pkg::BSR_W, 32'h0000_005a, dr_out);
    check(dr_out, {sbt_pkg::BSR_FILL, 6'h16});
    check(scan_out, 4'ha);
  endtask : t_sample_extest

  task automatic t_samplez();
    ctl.load_ir(sbt_pkg::OP_SAMPLE_Z, ir_cap);
    check({ram_out_float, scan_out_sel}, 2'h2);
    set_pins(6'h09);
    ctl.scan_dr(sbt_pkg::BSR_W, 32'h0000_0000, dr_out);
    check(dr_out, {sbt_pkg::BSR_FILL, 6'h09});
  endtask : t_samplez

  // Five high edges from the middle of a data shift must still reach reset
  task automatic t_tlr();
    ctl.load_ir(sbt_pkg::OP_BYPASS, ir_cap);
    ctl.step(1'b1, 1'b1);
    ctl.step(1'b0, 1'b1);
    ctl.step(1'b0, 1'b1);
    ctl.go_reset();
    check(active_op, sbt_pkg::OP_IDCODE);
    ctl.scan_dr(sbt_pkg::ID_W, 32'h0000_0000, dr_out);
    check(dr_out, sbt_pkg::ID_VALUE);
  endtask : t_tlr

  initial begin
    reset_n = 1'b0;
    pin_in = 6'h00;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_idcode();
    t_bypass();
    t_sample_extest();
    t_samplez();
    t_tlr();
    print_verdict();
  end
endmodule : tb_top
